// *** tb/tpm_far_end.sv ***
// far-end model: terminal equipment driving one channel's pins
// assumes the bench calls its tasks; clocks stand still between calls
`timescale 1ns/1ps

module tpm_far_end (
  output logic       o_clk_fcs,
  output logic       o_pl_msg,
  output logic [7:0] o_bus_d,
  output logic       o_frm_clk,
  output logic [7:0] o_frm_d
);
  // all pins low until a task runs
  initial
    {o_clk_fcs, o_pl_msg, o_bus_d, o_frm_clk, o_frm_d} = 19'h0_0000;

  // one 154 ns bus clock period (slow bus rate), indicator low on an overhead byte
  task automatic bus_byte(input logic [7:0] d, input logic ovh);
    #3;
    o_clk_fcs = 1'h1;
    o_bus_d = d;
    o_pl_msg = !ovh;
    #77;
    o_clk_fcs = 1'h0;
    #74;
    o_bus_d = ~d;
  endtask : bus_byte

  // one frame clock period with commands and data set up before the rise
  task automatic frame_clk(input logic msg, input logic fcs, input logic [7:0] d);
    #3;
    o_pl_msg = msg;
    o_clk_fcs = fcs;
    o_frm_d = d;
    o_frm_clk = 1'h0;
    #80;
    o_frm_clk = 1'h1;
    #77;
  endtask : frame_clk

  // two payload bytes, then the check field command, then idle low
  task automatic hdlc_frame(input logic [7:0] a, input logic [7:0] b, input logic crc32);
    frame_clk(1'h1, 1'h0, a);
    frame_clk(1'h1, 1'h0, b);
    repeat (crc32 ? 4 : 2) frame_clk(1'h1, 1'h1, ~b);
    frame_clk(1'h0, 1'h0, ~b);
  endtask : hdlc_frame
endmodule : tpm_far_end

// *** tb/tpm_tx_input_monitor.sv ***
// checker on the ports of the three-channel transmit input block
// assumes it is bound into tpm_tx_input and runs on the core clock
`timescale 1ns/1ps

module tpm_tx_input_monitor (
  // clock and reset
  input wire logic            i_core_clk,
  input wire logic            i_rst_n,
  // watched ports
  input wire logic [2:0]      i_bus_enable,
  input wire logic [2:0]      i_hdlc_mode,
  input wire logic [2:0]      i_payload_or_msg_pin,
  input wire logic [2:0]      i_busclk_or_fcs_pin,
  input wire logic [2:0][7:0] i_tx_bus_data,
  input wire logic [2:0][7:0] o_bus_byte,
  input wire logic [2:0]      o_bus_is_overhead,
  input wire logic [2:0]      o_bus_valid,
  input wire logic [2:0]      i_payload_bit_req,
  input wire logic [2:0]      o_hdlc_bit_valid,
  input wire logic [2:0]      o_overrun
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // per channel relations between pins and outputs
  for (genvar c = 0; c < 3; c++)
  begin : g_ch
    a_bus_role:
    assert property (o_bus_valid[c] |-> $past(i_bus_enable[c])) else $error("bus sample off");
    a_bus_fall_edge:
    assert property (o_bus_valid[c] |-> !$past(i_busclk_or_fcs_pin[c], 2)
      && $past(i_busclk_or_fcs_pin[c], 6)) else $error("bus sample not on fall");
    a_bus_sample_data:
    assert property (o_bus_valid[c] |-> o_bus_byte[c] == $past(i_tx_bus_data[c], 3)
      && o_bus_is_overhead[c] == !$past(i_payload_or_msg_pin[c], 3)) else $error("bus data");
    a_bus_one_pulse:
    assert property (o_bus_valid[c] |=> !o_bus_valid[c]) else $error("bus valid too long");
    a_bit_answer:
    assert property (i_payload_bit_req[c] |=> o_hdlc_bit_valid[c]) else $error("no bit");
    a_bit_cause:
    assert property (o_hdlc_bit_valid[c] |-> $past(i_payload_bit_req[c])) else $error("bit");
    a_capture_mode:
    assert property (o_overrun[c] |-> !$past(i_bus_enable[c]) && $past(i_hdlc_mode[c]))
      else $error("capture outside message role");
    a_capture_cmd:
    assert property (o_overrun[c] |-> $past(i_payload_or_msg_pin[c], 4)
      || $past(i_busclk_or_fcs_pin[c], 4)) else $error("capture without command");
  end
endmodule : tpm_tx_input_monitor

bind tpm_tx_input tpm_tx_input_monitor mon (.i_core_clk, .i_rst_n, .i_bus_enable,
  .i_hdlc_mode, .i_payload_or_msg_pin, .i_busclk_or_fcs_pin, .i_tx_bus_data, .o_bus_byte,
  .o_bus_is_overhead, .o_bus_valid, .i_payload_bit_req, .o_hdlc_bit_valid, .o_overrun);

// *** tb/tpm_tx_input_test.sv ***
// self-checking bench for the three-channel transmit input block
// assumes one far-end model per channel drives the pins
`timescale 1ns/1ps

module tpm_tx_input_test;
  import tpm_pkg::*;
  logic            i_core_clk = 1'h0;
  logic            i_rst_n = 1'h0;
  logic [2:0]      bus_en = 3'h0;
  logic [2:0]      hdlc = 3'h0;
  logic [2:0]      crc32 = 3'h0;
  logic [2:0]      req = 3'h0;
  logic            pull_on = 1'h0;
  logic            got = 1'h0;
  logic            got_o;
  logic [7:0]      got_b;
  logic [23:0]     hist = 24'h00_0000;
  logic [2:0][7:0] bbyte;
  logic [2:0]      ovh, bv, hbit, hval, ovr;
  wire logic [2:0] fcs_w, msg_w, fc_w;
  wire logic [2:0][7:0] bd_w, fd_w;
  int              n_bv = 0, n_ovr = 0, n_flag = 0, n_mismatch = 0, checks = 0;

  // core clock
  always #5 i_core_clk = ~i_core_clk;

  // far-end models
  for (genvar c = 0; c < 3; c++)
  begin : g_far
    tpm_far_end far (.o_clk_fcs(fcs_w[c]), .o_pl_msg(msg_w[c]), .o_bus_d(bd_w[c]),
                     .o_frm_clk(fc_w[c]), .o_frm_d(fd_w[c]));
  end

  tpm_tx_input DUT (.i_core_clk, .i_rst_n, .i_bus_enable(bus_en), .i_hdlc_mode(hdlc),
    .i_crc32_sel(crc32), .i_payload_or_msg_pin(msg_w), .i_busclk_or_fcs_pin(fcs_w),
    .i_tx_bus_data(bd_w), .i_tx_frame_clock(fc_w), .i_tx_frame_data_in(fd_w),
    .o_bus_byte(bbyte), .o_bus_is_overhead(ovh), .o_bus_valid(bv), .i_payload_bit_req(req),
    .o_hdlc_bit(hbit), .o_hdlc_bit_valid(hval), .o_overrun(ovr));

  // framer stand-in: one bit request every second cycle
  always @(negedge i_core_clk)
    req <= (pull_on && !req[0]) ? 3'h7 : 3'h0;

  // collect channel 0 samples, serial bits and overruns where outputs are settled
  always @(negedge i_core_clk)
  begin
    if (bv[0])
    begin
      got_b = bbyte[0];
      got_o = ovh[0];
      n_bv++;
    end
    if (ovr[0])
      n_ovr++;
    if (hval[0])
    begin
      hist = {hbit[0], hist[23:1]};
      if (hist == {8'h3C, 8'hA5, 8'h7E})
        got = 1'h1;
      if (hist[23:8] == 16'h7E7E)
        n_flag++;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // bus enabled: one sample per falling bus clock, low indicator marks overhead
  task automatic t_bus;
    @(negedge i_core_clk);
    bus_en = 3'h1;
    n_bv = 0;
    g_far[0].far.bus_byte(8'h5A, 1'h1);
    check("bus byte", got_b, 8'h5A);
    check("overhead", got_o, 1'h1);
    g_far[0].far.bus_byte(8'hC3, 1'h0);
    check("bus byte", got_b, 8'hC3);
    check("overhead", got_o, 1'h0);
    check("samples", n_bv, 2);
  endtask : t_bus

  // bus disabled: nothing sampled
  task automatic t_off;
    @(negedge i_core_clk);
    bus_en = 3'h0;
    n_bv = 0;
    g_far[0].far.bus_byte(8'h33, 1'h0);
    check("samples off", n_bv, 0);
  endtask : t_off

  // message low: data on the pins ignored, flags only
  task automatic t_idle;
    @(negedge i_core_clk);
    hdlc = 3'h7;
    pull_on = 1'h1;
    repeat (40) @(negedge i_core_clk);
    got = 1'h0;
    n_flag = 0;
    repeat (2) g_far[0].far.frame_clk(1'h0, 1'h0, 8'hA5);
    repeat (2) g_far[0].far.frame_clk(1'h0, 1'h0, 8'h3C);
    check("flags", n_flag >= 3, 1'h1);
    check("ignored data", got, 1'h0);
  endtask : t_idle

  // message high: bytes follow a flag, for both check field sizes
  task automatic t_frame;
    for (int s = 0; s < 2; s++)
    begin
      @(negedge i_core_clk);
      crc32 = s[0] ? 3'h7 : 3'h0;
      got = 1'h0;
      g_far[0].far.hdlc_frame(8'hA5, 8'h3C, s[0]);
      repeat (60) @(negedge i_core_clk);
      check("frame", got, 1'h1);
    end
  endtask : t_frame

  // bus enabled: the pin is an indicator, no message capture
  task automatic t_role;
    @(negedge i_core_clk);
    crc32 = 3'h0;
    bus_en = 3'h1;
    got = 1'h0;
    g_far[0].far.hdlc_frame(8'hA5, 8'h3C, 1'h0);
    repeat (60) @(negedge i_core_clk);
    check("no capture", got, 1'h0);
    bus_en = 3'h0;
  endtask : t_role

  // framer stalled: one octet waits, the next three are dropped
  task automatic t_ovr;
    @(negedge i_core_clk);
    pull_on = 1'h0;
    repeat (20) @(negedge i_core_clk);
    n_ovr = 0;
    g_far[0].far.hdlc_frame(8'hA5, 8'h3C, 1'h0);
    repeat (10) @(negedge i_core_clk);
    check("overruns", n_ovr, 3);
    pull_on = 1'h1;
  endtask : t_ovr

  task automatic summarize;
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // reset, then the scenarios in turn
  initial
  begin
    repeat (6) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_rst_n = 1'h1;
    repeat (4) @(negedge i_core_clk);
    t_bus();
    t_off();
    t_idle();
    t_frame();
    t_role();
    t_ovr();
    summarize();
  end

  // watchdog far beyond the expected run of some 730 cycles
  initial
  begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule : tpm_tx_input_test

// *** verilog/tpm_pkg.sv ***
// constants for the three-channel transmit payload marker and frame message input block
// assumes one core clock, and pins that arrive from outside its domain
//
// Behaviour
// [R1] per channel, bus enable picks payload indicator role, else send-message role
// [R2] far side drives indicator low on overhead bytes, high otherwise
// [R3] payload indicator is sampled on the falling bus clock edge
// [R4] far side uses send-message only in HDLC mode, else ties it low
// [R5] while send-message is high, capture frame data on each rising frame clock
// [R6] captured bytes go into an HDLC frame carried in outgoing payload bits
// [R7] while send-message is low, ignore data and send continuous 0x7E flags
// [R8] far side runs the bus clock at 19.44 or 6.48 MHz
// [R9] far side holds send-checksum two frame clocks for a CRC-16 field
// [R10] far side holds send-checksum four frame clocks for a CRC-32 field
// [R11] far side keeps send-message high per frame, checksum before lowering it
package tpm_pkg;

  localparam int          NUM_CH      = 3;
  localparam int          BYTE_W      = 8;
  localparam int          CRC_W       = 32;

  // bit positions inside the per-channel synchroniser vector
  localparam int          SB_BUSCLK   = 0;   // bus clock / send-checksum pin
  localparam int          SB_DUAL     = 1;   // payload indicator / send-message pin
  localparam int          SB_BUSD     = 2;   // bus data, eight bits up
  localparam int          SB_FRMCLK   = 10;  // frame clock
  localparam int          SB_FRMD     = 11;  // frame data, eight bits up
  localparam int          SYNC_W      = 19;

  // hdlc constants
  localparam logic [7:0]  FLAG_OCTET  = 8'h7E;
  localparam logic [2:0]  STUFF_LIMIT = 3'h5;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam logic [31:0] CRC16_POLY  = 32'h0000_8408;
  localparam logic [31:0] CRC32_POLY  = 32'hEDB8_8320;
  localparam logic [31:0] CRC16_INIT  = 32'h0000_FFFF;
  localparam logic [31:0] CRC32_INIT  = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC16_MASK  = 32'h0000_FFFF;

  // kind of the octet held in the buffer or the shifter
  typedef enum logic [1:0]
  {
    K_FLAG = 2'b00,
    K_DATA = 2'b01,
    K_FCS  = 2'b10
  } tpm_kind_t;

endpackage : tpm_pkg

// *** verilog/tpm_sync.sv ***
// two-flop synchroniser with edge detection for a vector of pin inputs
// assumes all inputs come from outside the core clock domain
`timescale 1ns/1ps

module tpm_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  // raw pins
  input  wire logic [W-1:0] i_async,
  // synchronised outputs
  output logic      [W-1:0] o_sync,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;
  logic [W-1:0] prev_d;
  logic [2:0]   arm_q;
  logic [2:0]   arm_d;

  // next values: first stage feeds only the second
  always_comb
  begin
    meta_d = i_async;
    sync_d = meta_q;
    prev_d = sync_q;
    arm_d  = {arm_q[1:0], 1'b1};
  end

  // register stages
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
      arm_q  <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
      arm_q  <= arm_d;
    end
  end

  // edges held off until every stage carries pin values, so a pin idling high
  // gives no false edge after reset
  assign o_sync = sync_q;
  assign o_rise = arm_q[2] ? (sync_q & ~prev_q) : '0;
  assign o_fall = arm_q[2] ? (~sync_q & prev_q) : '0;

endmodule : tpm_sync

// *** verilog/tpm_tx_input.sv ***
// per-channel transmit input: telecom bus payload marking or hdlc message capture
// assumes framer pulls payload bits with i_payload_bit_req on the core clock
`timescale 1ns/1ps

module tpm_tx_input
  import tpm_pkg::*;
(
  // clock and reset
  input  wire logic                                        i_core_clk,
  input  wire logic                                        i_rst_n,
  // per-channel configuration
  input  wire logic [tpm_pkg::NUM_CH-1:0]                  i_bus_enable,
  input  wire logic [tpm_pkg::NUM_CH-1:0]                  i_hdlc_mode,
  input  wire logic [tpm_pkg::NUM_CH-1:0]                  i_crc32_sel,
  // dual-role pins
  input  wire logic [tpm_pkg::NUM_CH-1:0]                  i_payload_or_msg_pin,
  input  wire logic [tpm_pkg::NUM_CH-1:0]                  i_busclk_or_fcs_pin,
  // telecom bus data pins
  input  wire logic [tpm_pkg::NUM_CH-1:0][tpm_pkg::BYTE_W-1:0] i_tx_bus_data,
  // hdlc input pins
  input  wire logic [tpm_pkg::NUM_CH-1:0]                  i_tx_frame_clock,
  input  wire logic [tpm_pkg::NUM_CH-1:0][tpm_pkg::BYTE_W-1:0] i_tx_frame_data_in,
  // telecom bus samples
  output logic      [tpm_pkg::NUM_CH-1:0][tpm_pkg::BYTE_W-1:0] o_bus_byte,
  output logic      [tpm_pkg::NUM_CH-1:0]                  o_bus_is_overhead,
  output logic      [tpm_pkg::NUM_CH-1:0]                  o_bus_valid,
  // hdlc bit stream toward the framer payload
  input  wire logic [tpm_pkg::NUM_CH-1:0]                  i_payload_bit_req,
  output logic      [tpm_pkg::NUM_CH-1:0]                  o_hdlc_bit,
  output logic      [tpm_pkg::NUM_CH-1:0]                  o_hdlc_bit_valid,
  output logic      [tpm_pkg::NUM_CH-1:0]                  o_overrun
);

  import tpm_pkg::*;

  // one reflected crc step, masked to 16 bits in crc-16 mode
  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c,
                                                input logic             b,
                                                input logic             is32);
    logic [CRC_W-1:0] r;
    r = c >> 1;
    if (c[0] ^ b)
      r = r ^ (is32 ? CRC32_POLY : CRC16_POLY);
    crc_step = is32 ? r : (r & CRC16_MASK);
  endfunction : crc_step

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      logic [SYNC_W-1:0] s_lvl;
      logic [SYNC_W-1:0] s_rise;
      logic [SYNC_W-1:0] s_fall;

      // every pin of the channel passes two flops before use
      tpm_sync #(
        .W        (SYNC_W)
      ) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    ({i_tx_frame_data_in[ch], i_tx_frame_clock[ch], i_tx_bus_data[ch],
                      i_payload_or_msg_pin[ch], i_busclk_or_fcs_pin[ch]}),
        .o_sync     (s_lvl),
        .o_rise     (s_rise),
        .o_fall     (s_fall)
      );

      // telecom bus sample state
      logic [BYTE_W-1:0] bus_byte_q;
      logic [BYTE_W-1:0] bus_byte_d;
      logic              bus_oh_q;
      logic              bus_oh_d;
      logic              bus_v_q;
      logic              bus_v_d;

      // sample data and indicator on falling bus clock when bus enabled
      always_comb
      begin
        bus_byte_d = bus_byte_q;
        bus_oh_d   = bus_oh_q;
        bus_v_d    = 1'b0;
        if (i_bus_enable[ch] && s_fall[SB_BUSCLK])                  // [R1] [R3]
        begin
          bus_byte_d = s_lvl[SB_BUSD +: BYTE_W];
          bus_oh_d   = ~s_lvl[SB_DUAL];                             // [R2]
          bus_v_d    = 1'b1;
        end
      end

      // register bus samples
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rst_n)
        begin
          bus_byte_q <= '0;
          bus_oh_q   <= 1'b0;
          bus_v_q    <= 1'b0;
        end
        else
        begin
          bus_byte_q <= bus_byte_d;
          bus_oh_q   <= bus_oh_d;
          bus_v_q    <= bus_v_d;
        end
      end

      assign o_bus_byte[ch]        = bus_byte_q;
      assign o_bus_is_overhead[ch] = bus_oh_q;
      assign o_bus_valid[ch]       = bus_v_q;

      // hdlc state: one-octet holding buffer, shifter and crc
      logic [BYTE_W-1:0] hold_q;
      logic [BYTE_W-1:0] hold_d;
      tpm_kind_t         hold_k_q;
      tpm_kind_t         hold_k_d;
      logic              hold_v_q;
      logic              hold_v_d;
      logic [BYTE_W-1:0] sh_q;
      logic [BYTE_W-1:0] sh_d;
      tpm_kind_t         sh_k_q;
      tpm_kind_t         sh_k_d;
      logic [2:0]        bit_q;
      logic [2:0]        bit_d;
      logic [2:0]        ones_q;
      logic [2:0]        ones_d;
      logic [CRC_W-1:0]  crc_q;
      logic [CRC_W-1:0]  crc_d;
      logic              out_q;
      logic              out_d;
      logic              out_v_q;
      logic              out_v_d;
      logic              ovr_q;
      logic              ovr_d;
      logic              active;
      logic              push;
      logic              push_fcs;
      logic              load;
      logic [CRC_W-1:0]  crc_n;

      assign active   = !i_bus_enable[ch] && i_hdlc_mode[ch];       // [R1]
      // checksum request outranks message data on the same frame clock edge
      assign push_fcs = active && s_rise[SB_FRMCLK] && s_lvl[SB_BUSCLK];
      assign push     = active && s_rise[SB_FRMCLK]
                        && (s_lvl[SB_BUSCLK] || s_lvl[SB_DUAL]);    // [R5]

      // next hdlc state: capture, stuff, serialise, checksum
      always_comb
      begin
        hold_d   = hold_q;
        hold_k_d = hold_k_q;
        hold_v_d = hold_v_q;
        sh_d     = sh_q;
        sh_k_d   = sh_k_q;
        bit_d    = bit_q;
        ones_d   = ones_q;
        crc_d    = crc_q;
        crc_n    = crc_q;
        out_d    = out_q;
        out_v_d  = 1'b0;
        ovr_d    = 1'b0;
        load     = 1'b0;
        if (i_payload_bit_req[ch])
        begin
          out_v_d = 1'b1;
          if (ones_q == STUFF_LIMIT)
          begin
            // stuffed zero, shifter holds; also lands before a closing flag
            out_d  = 1'b0;
            ones_d = '0;
          end
          else
          begin
            out_d  = sh_q[0];                                       // [R6]
            ones_d = (sh_q[0] && sh_k_q != K_FLAG) ? ones_q + 3'h1 : '0;
            if (sh_k_q == K_DATA)
              crc_n = crc_step(crc_q, sh_q[0], i_crc32_sel[ch]);
            crc_d = crc_n;
            sh_d  = sh_q >> 1;
            bit_d = bit_q + 3'h1;
            if (bit_q == LAST_BIT)
            begin
              load  = 1'b1;
              bit_d = '0;
              if (hold_v_q)
              begin
                sh_k_d   = hold_k_q;
                hold_v_d = 1'b0;
                if (hold_k_q == K_FCS)
                begin
                  // next checksum octet, inverted, low byte first
                  sh_d  = ~crc_n[BYTE_W-1:0];
                  crc_d = crc_n >> BYTE_W;
                end
                else
                  sh_d = hold_q;
              end
              else
              begin
                // nothing waiting: flag, and restart crc for the next frame
                sh_d   = FLAG_OCTET;                                // [R7]
                sh_k_d = K_FLAG;
                crc_d  = i_crc32_sel[ch] ? CRC32_INIT : CRC16_INIT;
              end
            end
          end
        end
        if (push)
        begin
          if (hold_v_q && !load)
            ovr_d = 1'b1;                                           // octet dropped
          else
          begin
            hold_v_d = 1'b1;
            hold_d   = s_lvl[SB_FRMD +: BYTE_W];                    // [R5]
            hold_k_d = push_fcs ? K_FCS : K_DATA;                   // [R9] [R10]
          end
        end
      end

      // register hdlc state
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rst_n)
        begin
          hold_q   <= '0;
          hold_k_q <= K_FLAG;
          hold_v_q <= 1'b0;
          sh_q     <= FLAG_OCTET;
          sh_k_q   <= K_FLAG;
          bit_q    <= '0;
          ones_q   <= '0;
          crc_q    <= CRC16_INIT;
          out_q    <= 1'b0;
          out_v_q  <= 1'b0;
          ovr_q    <= 1'b0;
        end
        else
        begin
          hold_q   <= hold_d;
          hold_k_q <= hold_k_d;
          hold_v_q <= hold_v_d;
          sh_q     <= sh_d;
          sh_k_q   <= sh_k_d;
          bit_q    <= bit_d;
          ones_q   <= ones_d;
          crc_q    <= crc_d;
          out_q    <= out_d;
          out_v_q  <= out_v_d;
          ovr_q    <= ovr_d;
        end
      end

      assign o_hdlc_bit[ch]       = out_q;
      assign o_hdlc_bit_valid[ch] = out_v_q;
      assign o_overrun[ch]        = ovr_q;
    end
  endgenerate

endmodule : tpm_tx_input
